// ===== src/actr_transfer.sv
// Accumulator-to-register transfer group: decode, execute and register port
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Word 0x00E copies all four accumulator bits into the second register.
// - Word 0x2A8 loads the accumulator into the port output structure control.
// - Word 0x029 loads accumulator bits 2..0 into the pointer; bit 3 ignored.
// - Word 0x01A puts the second register into the wide register's upper nibble.
// - The same word puts the accumulator into the low nibble, both halves together.
// - Word 0x228 loads the accumulator into port drive control 0 in one cycle.
// - Word 0x229 loads the accumulator into port drive control 1 in one cycle.
// - Word 0x22A loads the accumulator into port drive control 2 in one cycle.
// - Word 0x22B loads the accumulator into port drive control 3 in one cycle.
module actr_transfer
   import actr_pkg::*;
#(
   parameter int unsigned DATA_WIDTH = DATA_W,
   parameter int unsigned ADDR_WIDTH = ADDR_W
)
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  instr_valid,
   input  wire logic [INSTR_W-1:0]    instr_word,
   input  wire logic [ACC_W-1:0]      acc_val,
   input  wire logic                  carry_in,
   input  wire logic [ADDR_WIDTH-1:0] reg_addr,
   input  wire logic [DATA_WIDTH-1:0] reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DATA_WIDTH-1:0] reg_rdata,
   output logic      [ACC_W-1:0]      second_reg,
   output logic      [PTR_W-1:0]      pointer_reg,
   output logic      [WIDE_W-1:0]     wide_reg,
   output logic      [ACC_W-1:0]      port_output_structure_ctrl,
   output logic      [ACC_W-1:0]      port_drive_ctrl_0,
   output logic      [ACC_W-1:0]      port_drive_ctrl_1,
   output logic      [ACC_W-1:0]      port_drive_ctrl_2,
   output logic      [ACC_W-1:0]      port_drive_ctrl_3,
   output logic                       op_done,
   output logic                       op_foreign,
   output logic                       carry_out,
   output logic                       skip_next
);

   // Decoded op for the word presented this cycle
   actr_op_t op;

   actr_decoder u_decoder (
      .instr_word  (instr_word),
      .instr_valid (instr_valid),
      .op          (op)
   );

   // Op hit strobes
   wire logic hit_b;
   wire logic hit_style;
   wire logic hit_ptr;
   wire logic hit_pack;
   wire logic hit_drv0;
   wire logic hit_drv1;
   wire logic hit_drv2;
   wire logic hit_drv3;
   wire logic hit_any;
   wire logic hit_foreign;

   assign hit_b       = (op == OP_TO_B);
   assign hit_style   = (op == OP_STYLE);
   assign hit_ptr     = (op == OP_POINTER);
   assign hit_pack    = (op == OP_PACK);
   assign hit_drv0    = (op == OP_DRIVE_0);
   assign hit_drv1    = (op == OP_DRIVE_1);
   assign hit_drv2    = (op == OP_DRIVE_2);
   assign hit_drv3    = (op == OP_DRIVE_3);
   assign hit_foreign = (op == OP_FOREIGN);
   assign hit_any     = instr_valid & ~hit_foreign;

   // Bus write decode
   wire logic wr_b;
   wire logic wr_ptr;
   wire logic wr_wide;
   wire logic wr_style;
   wire logic wr_drv0;
   wire logic wr_drv1;
   wire logic wr_drv2;
   wire logic wr_drv3;

   assign wr_b     = reg_wr & (reg_addr == ADR_SECOND_REG);
   assign wr_ptr   = reg_wr & (reg_addr == ADR_POINTER_REG);
   assign wr_wide  = reg_wr & (reg_addr == ADR_WIDE_REG);
   assign wr_style = reg_wr & (reg_addr == ADR_OUTPUT_STYLE);
   assign wr_drv0  = reg_wr & (reg_addr == ADR_DRIVE_CTRL_0);
   assign wr_drv1  = reg_wr & (reg_addr == ADR_DRIVE_CTRL_1);
   assign wr_drv2  = reg_wr & (reg_addr == ADR_DRIVE_CTRL_2);
   assign wr_drv3  = reg_wr & (reg_addr == ADR_DRIVE_CTRL_3);

   // Register state
   logic [ACC_W-1:0]  second_q;
   logic [ACC_W-1:0]  second_d;
   logic [PTR_W-1:0]  ptr_q;
   logic [PTR_W-1:0]  ptr_d;
   logic [WIDE_W-1:0] wide_q;
   logic [WIDE_W-1:0] wide_d;
   logic [ACC_W-1:0]  style_q;
   logic [ACC_W-1:0]  style_d;
   logic [ACC_W-1:0]  drv0_q;
   logic [ACC_W-1:0]  drv0_d;
   logic [ACC_W-1:0]  drv1_q;
   logic [ACC_W-1:0]  drv1_d;
   logic [ACC_W-1:0]  drv2_q;
   logic [ACC_W-1:0]  drv2_d;
   logic [ACC_W-1:0]  drv3_q;
   logic [ACC_W-1:0]  drv3_d;

   assign second_d = actr_next_nib(hit_b, acc_val, wr_b, reg_wdata[3:0], second_q);
   assign style_d  = actr_next_nib(hit_style, acc_val, wr_style, reg_wdata[3:0],
                                   style_q);
   assign drv0_d   = actr_next_nib(hit_drv0, acc_val, wr_drv0, reg_wdata[3:0], drv0_q);
   assign drv1_d   = actr_next_nib(hit_drv1, acc_val, wr_drv1, reg_wdata[3:0], drv1_q);
   assign drv2_d   = actr_next_nib(hit_drv2, acc_val, wr_drv2, reg_wdata[3:0], drv2_q);
   assign drv3_d   = actr_next_nib(hit_drv3, acc_val, wr_drv3, reg_wdata[3:0], drv3_q);

   // Pointer keeps only accumulator bits 2..0
   assign ptr_d = hit_ptr ? acc_val[PTR_W-1:0] :
                  (wr_ptr ? reg_wdata[PTR_W-1:0] : ptr_q);

   // Upper half takes the second register as it stood before this edge
   assign wide_d = hit_pack ? {second_q, acc_val} :
                   (wr_wide ? reg_wdata[WIDE_W-1:0] : wide_q);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         second_q <= RST_NIBBLE;
         ptr_q    <= RST_PTR;
         wide_q   <= RST_WIDE;
         style_q  <= RST_NIBBLE;
      end
      else
      begin
         second_q <= second_d;
         ptr_q    <= ptr_d;
         wide_q   <= wide_d;
         style_q  <= style_d;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         drv0_q <= RST_NIBBLE;
         drv1_q <= RST_NIBBLE;
         drv2_q <= RST_NIBBLE;
         drv3_q <= RST_NIBBLE;
      end
      else
      begin
         drv0_q <= drv0_d;
         drv1_q <= drv1_d;
         drv2_q <= drv2_d;
         drv3_q <= drv3_d;
      end
   end

   // Completion, carry and skip: every op finishes on the edge that takes it
   logic done_q;
   logic foreign_q;
   logic carry_q;
   logic skip_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         done_q    <= 1'b0;
         foreign_q <= 1'b0;
         carry_q   <= 1'b0;
         skip_q    <= 1'b0;
      end
      else
      begin
         done_q    <= hit_any;
         foreign_q <= hit_foreign;
         carry_q   <= carry_in;
         skip_q    <= 1'b0;
      end
   end

   // Activity record for software
   logic [8:0]       last_op_q;
   logic [8:0]       last_op_d;
   logic [CNT_W-1:0] exec_cnt_q;
   logic [CNT_W-1:0] exec_cnt_d;
   logic [CNT_W-1:0] foreign_cnt_q;
   logic [CNT_W-1:0] foreign_cnt_d;

   assign last_op_d     = hit_any ? op : last_op_q;
   assign exec_cnt_d    = hit_any ? exec_cnt_q + 8'h01 : exec_cnt_q;
   assign foreign_cnt_d = hit_foreign ? foreign_cnt_q + 8'h01 : foreign_cnt_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         last_op_q     <= OP_NONE;
         exec_cnt_q    <= RST_COUNT;
         foreign_cnt_q <= RST_COUNT;
      end
      else
      begin
         last_op_q     <= last_op_d;
         exec_cnt_q    <= exec_cnt_d;
         foreign_cnt_q <= foreign_cnt_d;
      end
   end

   // Read path: data stands only in the cycle after the read strobe
   wire logic [DATA_WIDTH-1:0] rd_mux;
   logic      [DATA_WIDTH-1:0] rdata_q;
   logic      [DATA_WIDTH-1:0] rdata_d;

   assign rd_mux =
      (reg_addr == ADR_SECOND_REG)   ? actr_pad_nib(second_q)      :
      (reg_addr == ADR_POINTER_REG)  ? {5'h00, ptr_q}              :
      (reg_addr == ADR_WIDE_REG)     ? wide_q                      :
      (reg_addr == ADR_OUTPUT_STYLE) ? actr_pad_nib(style_q)       :
      (reg_addr == ADR_DRIVE_CTRL_0) ? actr_pad_nib(drv0_q)        :
      (reg_addr == ADR_DRIVE_CTRL_1) ? actr_pad_nib(drv1_q)        :
      (reg_addr == ADR_DRIVE_CTRL_2) ? actr_pad_nib(drv2_q)        :
      (reg_addr == ADR_DRIVE_CTRL_3) ? actr_pad_nib(drv3_q)        :
      (reg_addr == ADR_LAST_OP)      ? last_op_q[7:0]              :
      (reg_addr == ADR_EXEC_COUNT)   ? exec_cnt_q                  :
      (reg_addr == ADR_FOREIGN_CNT)  ? foreign_cnt_q               :
                                       RST_RDATA;

   assign rdata_d = reg_rd ? rd_mux : RST_RDATA;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdata_q <= RST_RDATA;
      else
         rdata_q <= rdata_d;
   end

   // Outputs straight from flip-flops
   assign reg_rdata                  = rdata_q;
   assign second_reg                 = second_q;
   assign pointer_reg                = ptr_q;
   assign wide_reg                   = wide_q;
   assign port_output_structure_ctrl = style_q;
   assign port_drive_ctrl_0          = drv0_q;
   assign port_drive_ctrl_1          = drv1_q;
   assign port_drive_ctrl_2          = drv2_q;
   assign port_drive_ctrl_3          = drv3_q;
   assign op_done                    = done_q;
   assign op_foreign                 = foreign_q;
   assign carry_out                  = carry_q;
   assign skip_next                  = skip_q;

endmodule : actr_transfer

`default_nettype wire

// ===== src/actr_pkg.sv
// Shared constants, op codes, register map and the instruction decoder
`default_nettype none

package actr_pkg;

   localparam int unsigned INSTR_W = 10;
   localparam int unsigned ACC_W   = 4;
   localparam int unsigned PTR_W   = 3;
   localparam int unsigned WIDE_W  = 8;
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned ADDR_W  = 4;
   localparam int unsigned CNT_W   = 8;

   // Instruction words of the transfer group
   localparam logic [9:0] OPC_COPY_ACC_TO_SECOND_REG       = 10'h00E;
   localparam logic [9:0] OPC_LOAD_PORT_OUTPUT_STYLE       = 10'h2A8;
   localparam logic [9:0] OPC_LOAD_LOW3_TO_POINTER_REG     = 10'h029;
   localparam logic [9:0] OPC_PACK_TWO_NIBBLES_TO_WIDE_REG = 10'h01A;
   localparam logic [9:0] OPC_LOAD_PORT_DRIVE_CTRL_0       = 10'h228;
   localparam logic [9:0] OPC_LOAD_PORT_DRIVE_CTRL_1       = 10'h229;
   localparam logic [9:0] OPC_LOAD_PORT_DRIVE_CTRL_2       = 10'h22A;
   localparam logic [9:0] OPC_LOAD_PORT_DRIVE_CTRL_3       = 10'h22B;

   // Register map, word addresses on the plain register port
   localparam logic [3:0] ADR_SECOND_REG   = 4'h0;
   localparam logic [3:0] ADR_POINTER_REG  = 4'h1;
   localparam logic [3:0] ADR_WIDE_REG     = 4'h2;
   localparam logic [3:0] ADR_OUTPUT_STYLE = 4'h3;
   localparam logic [3:0] ADR_DRIVE_CTRL_0 = 4'h4;
   localparam logic [3:0] ADR_DRIVE_CTRL_1 = 4'h5;
   localparam logic [3:0] ADR_DRIVE_CTRL_2 = 4'h6;
   localparam logic [3:0] ADR_DRIVE_CTRL_3 = 4'h7;
   localparam logic [3:0] ADR_LAST_OP      = 4'h8;
   localparam logic [3:0] ADR_EXEC_COUNT   = 4'h9;
   localparam logic [3:0] ADR_FOREIGN_CNT  = 4'hA;

   // Values after reset
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [2:0] RST_PTR    = 3'h0;
   localparam logic [7:0] RST_WIDE   = 8'h00;
   localparam logic [7:0] RST_COUNT  = 8'h00;
   localparam logic [7:0] RST_RDATA  = 8'h00;

   // One one-hot op per instruction of the group and one for foreign words; OP_NONE is zero
   typedef enum logic [8:0] {
      OP_NONE     = 9'h000,
      OP_TO_B     = 9'h001,
      OP_STYLE    = 9'h002,
      OP_POINTER  = 9'h004,
      OP_PACK     = 9'h008,
      OP_DRIVE_0  = 9'h010,
      OP_DRIVE_1  = 9'h020,
      OP_DRIVE_2  = 9'h040,
      OP_DRIVE_3  = 9'h080,
      OP_FOREIGN  = 9'h100
   } actr_op_t;

   // Next value of a nibble register: the instruction load wins over a bus write
   function automatic logic [3:0] actr_next_nib(input logic       op_hit,
                                                input logic [3:0] op_val,
                                                input logic       bus_hit,
                                                input logic [3:0] bus_val,
                                                input logic [3:0] cur);
      actr_next_nib = op_hit ? op_val : (bus_hit ? bus_val : cur);
   endfunction : actr_next_nib

   // Zero-extend a nibble onto the read data bus
   function automatic logic [7:0] actr_pad_nib(input logic [3:0] nib);
      actr_pad_nib = {4'h0, nib};
   endfunction : actr_pad_nib

endpackage : actr_pkg

`default_nettype wire

`timescale 1ns/10ps
`default_nettype none

// Maps one instruction word to its op; words outside the group give OP_FOREIGN
module actr_decoder
   import actr_pkg::*;
(
   input  wire logic [9:0] instr_word,
   input  wire logic       instr_valid,
   output var  actr_op_t   op
);

   wire actr_op_t word_op;

   assign word_op =
      (instr_word == OPC_COPY_ACC_TO_SECOND_REG)       ? OP_TO_B    :
      (instr_word == OPC_LOAD_PORT_OUTPUT_STYLE)       ? OP_STYLE   :
      (instr_word == OPC_LOAD_LOW3_TO_POINTER_REG)     ? OP_POINTER :
      (instr_word == OPC_PACK_TWO_NIBBLES_TO_WIDE_REG) ? OP_PACK    :
      (instr_word == OPC_LOAD_PORT_DRIVE_CTRL_0)       ? OP_DRIVE_0 :
      (instr_word == OPC_LOAD_PORT_DRIVE_CTRL_1)       ? OP_DRIVE_1 :
      (instr_word == OPC_LOAD_PORT_DRIVE_CTRL_2)       ? OP_DRIVE_2 :
      (instr_word == OPC_LOAD_PORT_DRIVE_CTRL_3)       ? OP_DRIVE_3 :
                                                         OP_FOREIGN;

   assign op = instr_valid ? word_op : OP_NONE;

endmodule : actr_decoder

`default_nettype wire

// ===== test/actr_transfer_checker.sv
// Concurrent checks of the transfer group at its top ports
`timescale 1ns/10ps
`default_nettype none
module actr_transfer_checker
   import actr_pkg::*;
(
   input wire logic               ref_clk,
   input wire logic               rst,
   input wire logic               instr_valid,
   input wire logic [INSTR_W-1:0] instr_word,
   input wire logic [ACC_W-1:0]   acc_val,
   input wire logic               carry_in,
   input wire logic [ACC_W-1:0]   second_reg,
   input wire logic [PTR_W-1:0]   pointer_reg,
   input wire logic [WIDE_W-1:0]  wide_reg,
   input wire logic [ACC_W-1:0]   port_output_structure_ctrl,
   input wire logic [ACC_W-1:0]   port_drive_ctrl_0,
   input wire logic [ACC_W-1:0]   port_drive_ctrl_1,
   input wire logic [ACC_W-1:0]   port_drive_ctrl_2,
   input wire logic [ACC_W-1:0]   port_drive_ctrl_3,
   input wire logic               op_done,
   input wire logic               op_foreign,
   input wire logic               carry_out,
   input wire logic               skip_next,
   input wire logic               reg_rd,
   input wire logic [DATA_W-1:0]  reg_rdata
);
   wire logic in_grp = instr_word inside {10'h00E, 10'h029, 10'h01A, 10'h2A8, [10'h228:10'h22B]};
   wire logic grp_hit = instr_valid && in_grp;
   wire logic frn_hit = instr_valid && !in_grp;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_take(logic [9:0] w);
      instr_valid && instr_word == w;
   endsequence
   a_copy_to_b: assert property (s_take(10'h00E) |=> second_reg == $past(acc_val))
      else $error("second register load wrong");
   a_style_load: assert property (
      s_take(10'h2A8) |=> port_output_structure_ctrl == $past(acc_val))
      else $error("output style load wrong");
   a_pointer_low3: assert property (
      s_take(10'h029) |=> pointer_reg == $past(acc_val[2:0]))
      else $error("pointer load wrong");
   a_pack_upper: assert property (
      s_take(10'h01A) |=> wide_reg[7:4] == $past(second_reg))
      else $error("wide upper nibble wrong");
   a_pack_lower: assert property (
      s_take(10'h01A) |=> wide_reg[3:0] == $past(acc_val))
      else $error("wide lower nibble wrong");
   a_drive_zero: assert property (s_take(10'h228) |=> port_drive_ctrl_0 == $past(acc_val))
      else $error("drive control 0 wrong");
   a_drive_one: assert property (s_take(10'h229) |=> port_drive_ctrl_1 == $past(acc_val))
      else $error("drive control 1 wrong");
   a_drive_two: assert property (s_take(10'h22A) |=> port_drive_ctrl_2 == $past(acc_val))
      else $error("drive control 2 wrong");
   a_drive_three: assert property (s_take(10'h22B) |=> port_drive_ctrl_3 == $past(acc_val))
      else $error("drive control 3 wrong");
   a_done_flags: assert property (
      !$past(rst) |-> op_done == $past(grp_hit) && op_foreign == $past(frn_hit))
      else $error("done or foreign flag wrong");
   a_carry_kept: assert property (!$past(rst) |-> carry_out == $past(carry_in))
      else $error("carry changed");
   a_never_skip: assert property (skip_next == 1'b0)
      else $error("skip raised");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
endmodule : actr_transfer_checker
bind actr_transfer actr_transfer_checker i_actr_transfer_checker (.*);
`default_nettype wire

// ===== test/actr_fetch_model.sv
// Instruction fetch model feeding the transfer group
`timescale 1ns/10ps
`default_nettype none
module actr_fetch_model
   import actr_pkg::*;
(
   input  wire logic               ref_clk,
   output var  logic               instr_valid,
   output var  logic [INSTR_W-1:0] instr_word,
   output var  logic [ACC_W-1:0]   acc_val,
   output var  logic               carry_in
);
   initial
   begin
      instr_valid = 1'b0;
      instr_word  = 10'h3FF;
      acc_val     = 4'h0;
      carry_in    = 1'b0;
   end
   task automatic fetch(input logic [9:0] w, input logic [3:0] a, input logic cy);
      instr_valid <= 1'b1;
      instr_word  <= w;
      acc_val     <= a;
      carry_in    <= cy;
      @(posedge ref_clk);
   endtask : fetch
   // Idle word and accumulator lines show junk, never the last value; carry_in holds
   task automatic release_bus();
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
      acc_val     <= ~acc_val;
      @(negedge ref_clk);
   endtask : release_bus
endmodule : actr_fetch_model
`default_nettype wire

// ===== test/actr_transfer_test.sv
// Self-checking bench for the accumulator transfer group
`timescale 1ns/10ps
`default_nettype none
module actr_transfer_test
   import actr_pkg::*;
;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       instr_valid, carry_in, op_done, op_foreign, carry_out, skip_next;
   logic [9:0] instr_word;
   logic [3:0] acc_val, second_reg, port_output_structure_ctrl, a;
   logic [3:0] port_drive_ctrl_0, port_drive_ctrl_1, port_drive_ctrl_2, port_drive_ctrl_3;
   logic [2:0] pointer_reg;
   logic [7:0] wide_reg, reg_rdata, expv;
   logic [7:0] tgt [8];
   int         failures = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   localparam logic [9:0] OPS [8] = '{10'h00E, 10'h029, 10'h01A, 10'h2A8,
      10'h228, 10'h229, 10'h22A, 10'h22B};
   actr_transfer i_actr_transfer (.*);
   actr_fetch_model i_actr_fetch_model (.*);
   assign tgt[0] = {4'h0, second_reg};
   assign tgt[1] = {5'h00, pointer_reg};
   assign tgt[2] = wide_reg;
   assign tgt[3] = {4'h0, port_output_structure_ctrl};
   assign tgt[4] = {4'h0, port_drive_ctrl_0};
   assign tgt[5] = {4'h0, port_drive_ctrl_1};
   assign tgt[6] = {4'h0, port_drive_ctrl_2};
   assign tgt[7] = {4'h0, port_drive_ctrl_3};
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic go(input logic [9:0] w, input logic [3:0] acc, input logic cy, input logic g);
      i_actr_fetch_model.fetch(w, acc, cy);
      i_actr_fetch_model.release_bus();
      chk({6'h00, op_done, op_foreign}, {6'h00, g, !g});
      chk({6'h00, carry_out, skip_next}, {6'h00, cy, 1'b0});
      @(posedge ref_clk);
   endtask : go
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      reg_wr    <= 1'b1;
      reg_addr  <= ad;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rdc(input logic [3:0] ad, input logic [7:0] exp);
      reg_rd   <= 1'b1;
      reg_addr <= ad;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, exp);
      @(posedge ref_clk);
   endtask : rdc
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i <= 10; i++)
      begin
         rdc(4'(i), 8'h00);
      end
      $display("reset values test done");
      for (int i = 0; i < 8; i++)
      begin
         a = 4'(15 - i);
         expv = (i == 1) ? {5'h00, a[2:0]} : ((i == 2) ? {4'hF, a} : {4'h0, a});
         go(OPS[i], a, i[0], 1'b1);
         chk(tgt[i], expv);
         rdc(4'(i), expv);
      end
      $display("single transfers test done");
      i_actr_fetch_model.fetch(OPS[0], 4'h3, 1'b0);
      i_actr_fetch_model.fetch(OPS[2], 4'h6, 1'b0);
      i_actr_fetch_model.release_bus();
      chk(wide_reg, 8'h36);
      @(posedge ref_clk);
      $display("back to back test done");
      go(10'h22C, 4'h5, 1'b1, 1'b0);
      rdc(ADR_DRIVE_CTRL_3, 8'h08);
      rdc(ADR_FOREIGN_CNT, 8'h01);
      $display("foreign word test done");
      reg_wr    <= 1'b1;
      reg_addr  <= ADR_DRIVE_CTRL_0;
      reg_wdata <= 8'h03;
      i_actr_fetch_model.fetch(OPS[4], 4'h9, 1'b0);
      reg_wr <= 1'b0;
      i_actr_fetch_model.release_bus();
      @(posedge ref_clk);
      rdc(ADR_DRIVE_CTRL_0, 8'h09);
      rdc(ADR_LAST_OP, 8'h10);
      wr(ADR_DRIVE_CTRL_2, 8'h0C);
      rdc(ADR_DRIVE_CTRL_2, 8'h0C);
      wr(4'hC, 8'h5A);
      rdc(4'hC, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         wr(4'(i), 8'(8'hE0 + i));
         rdc(4'(i), (i == 2) ? 8'hE2 : 8'(i));
      end
      wr(ADR_EXEC_COUNT, 8'hFF);
      rdc(ADR_EXEC_COUNT, 8'h0B);
      $display("bus and conflict test done");
      report_and_stop();
   end
endmodule : actr_transfer_test
`default_nettype wire
